// [dpw_pkg.sv]
package dpw_pkg;
	// ************************************************
	// Bus address and instruction byte layout
	// ************************************************
	localparam logic [5:0] DPW_ADDR_FIXED  = 6'h16;
	localparam int         DPW_RS_BIT      = 6;
	localparam int         DPW_SD_BIT      = 5;
	localparam int         DPW_RW_BIT      = 0;
	localparam logic [2:0] DPW_BIT_LAST    = 3'h7;
	localparam logic [2:0] DPW_BIT_FIRST   = 3'h0;

	// ************************************************
	// Wiper values
	// ************************************************
	localparam logic [7:0] DPW_MIDSCALE    = 8'h80;
	localparam logic [7:0] DPW_WIPER_RST   = 8'h80;

	// ************************************************
	// Receiver state and byte phase
	// ************************************************
	typedef enum logic [5:0] {
		DPW_IDLE = 6'b000001,
		DPW_RX   = 6'b000010,
		DPW_ACK  = 6'b000100,
		DPW_TX   = 6'b001000,
		DPW_MACK = 6'b010000,
		DPW_IGNR = 6'b100000
	} dpw_state_e;

	typedef enum logic [1:0] {
		DPW_PH_ADDR  = 2'h0,
		DPW_PH_INSTR = 2'h1,
		DPW_PH_DATA  = 2'h2
	} dpw_phase_e;
endpackage

// [dpw_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dpw_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] synced
);
	// Bus lines idle high, so the chain resets high to avoid a false START
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	assign synced = sync_q;
endmodule
`default_nettype wire

// [dpw_wiper_port.sv]
// Operation
// - Data rising while clock high is STOP; the port releases the data line.
// - Each received write data byte loads the wiper setting at its eighth bit, before the acknowledge.
// - Further data bytes in one write reuse the instruction already received.
// - Successive reads keep returning the wiper setting while addressed.
// - A read returns the current wiper setting contents.
// - Address-select pin level separates two devices on one bus.
// - Address is fixed 010110 plus the address-select pin, then read/write.
// - Midscale reset bit overwrites the wiper setting with the center-tap value.
// - Shutdown keeps the stored setting and still accepts new settings.
// - In a read the data byte follows the address acknowledge directly.
`timescale 1ns/1ps
`default_nettype none
module dpw_wiper_port (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       address_select_pin,
	output logic            sda_drv,
	output logic            sda_drv_en,
	output logic [7:0]      wiper_setting_register,
	output logic            shutdown_bit,
	output logic            midscale_reset_bit,
	output logic            wiper_update,
	output logic            addressed
);
	// ************************************************
	// Pin synchronisation and bus events
	// ************************************************
	logic [1:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_p_q;
	logic       sda_p_q;
	logic       adsel_q;

	dpw_sync #(.WIDTH(2)) u_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.raw     ({scl, sda}),
		.synced  (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// Strap is a static pin level but still crosses into this clock first
	logic adsel_m_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_p_q   <= 1'b1;
			sda_p_q   <= 1'b1;
			adsel_m_q <= 1'b0;
			adsel_q   <= 1'b0;
		end else begin
			scl_p_q   <= scl_s;
			sda_p_q   <= sda_s;
			adsel_m_q <= address_select_pin;
			adsel_q   <= adsel_m_q;
		end
	end

	function automatic logic addr_match(input logic [7:0] b, input logic sel);
		addr_match = (b[7:1] == {dpw_pkg::DPW_ADDR_FIXED, sel});
	endfunction

	// ************************************************
	// Serial state machine
	// ************************************************
	dpw_pkg::dpw_state_e st_q;
	dpw_pkg::dpw_state_e st_d;
	dpw_pkg::dpw_phase_e ph_q;
	dpw_pkg::dpw_phase_e ph_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [6:0] sh_q;
	logic [6:0] sh_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic       rw_q;
	logic       rw_d;
	logic       mack_q;
	logic       mack_d;
	logic       oe_q;
	logic       oe_d;
	logic [7:0] wiper_q;
	logic [7:0] wiper_d;
	logic       rs_q;
	logic       rs_d;
	logic       sd_q;
	logic       sd_d;
	logic       upd_q;
	logic       upd_d;
	logic [7:0] rx_byte;

	assign rx_byte = {sh_q, sda_s};

	always_comb begin
		st_d    = st_q;
		ph_d    = ph_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		rw_d    = rw_q;
		mack_d  = mack_q;
		oe_d    = oe_q;
		wiper_d = wiper_q;
		rs_d    = rs_q;
		sd_d    = sd_q;
		upd_d   = 1'b0;
		if (bus_start) begin
			// A repeated START also lands here and re-reads the address
			st_d  = dpw_pkg::DPW_RX;
			ph_d  = dpw_pkg::DPW_PH_ADDR;
			cnt_d = dpw_pkg::DPW_BIT_FIRST;
			oe_d  = 1'b0;
		end else if (bus_stop) begin
			st_d = dpw_pkg::DPW_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				dpw_pkg::DPW_RX: begin
					if (scl_rise) begin
						sh_d  = rx_byte[6:0];
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == dpw_pkg::DPW_BIT_LAST) begin
							st_d = dpw_pkg::DPW_ACK;
							case (ph_q)
								dpw_pkg::DPW_PH_ADDR: begin
									rw_d = rx_byte[dpw_pkg::DPW_RW_BIT];
									if (!addr_match(rx_byte, adsel_q)) begin
										st_d = dpw_pkg::DPW_IGNR;
									end
								end
								dpw_pkg::DPW_PH_INSTR: begin
									rs_d = rx_byte[dpw_pkg::DPW_RS_BIT];
									sd_d = rx_byte[dpw_pkg::DPW_SD_BIT];
									if (rx_byte[dpw_pkg::DPW_RS_BIT]) begin
										wiper_d = dpw_pkg::DPW_MIDSCALE;
										upd_d   = 1'b1;
									end
								end
								default: begin
									// Stored even in shutdown; instruction bits are kept
									wiper_d = rs_q ? dpw_pkg::DPW_MIDSCALE : rx_byte;
									upd_d   = 1'b1;
								end
							endcase
						end
					end
				end
				dpw_pkg::DPW_ACK: begin
					if (scl_fall) begin
						if (!oe_q) begin
							oe_d = 1'b1;
						end else if (ph_q == dpw_pkg::DPW_PH_ADDR && rw_q) begin
							st_d  = dpw_pkg::DPW_TX;
							tx_d  = wiper_q;
							oe_d  = ~wiper_q[7];
							cnt_d = dpw_pkg::DPW_BIT_FIRST;
						end else begin
							st_d  = dpw_pkg::DPW_RX;
							oe_d  = 1'b0;
							cnt_d = dpw_pkg::DPW_BIT_FIRST;
							// Instruction is only taken right after the address
							ph_d  = (ph_q == dpw_pkg::DPW_PH_ADDR) ? dpw_pkg::DPW_PH_INSTR
								: dpw_pkg::DPW_PH_DATA;
						end
					end
				end
				dpw_pkg::DPW_TX: begin
					if (scl_fall) begin
						if (cnt_q == dpw_pkg::DPW_BIT_LAST) begin
							st_d   = dpw_pkg::DPW_MACK;
							oe_d   = 1'b0;
							mack_d = 1'b0;
						end else begin
							tx_d  = {tx_q[6:0], 1'b0};
							oe_d  = ~tx_q[6];
							cnt_d = cnt_q + 3'h1;
						end
					end
				end
				dpw_pkg::DPW_MACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							st_d = dpw_pkg::DPW_IGNR;
						end else begin
							mack_d = 1'b1;
						end
					end else if (scl_fall && mack_q) begin
						st_d  = dpw_pkg::DPW_TX;
						tx_d  = wiper_q;
						oe_d  = ~wiper_q[7];
						cnt_d = dpw_pkg::DPW_BIT_FIRST;
					end
				end
				dpw_pkg::DPW_IGNR: begin
					oe_d = 1'b0;
				end
				dpw_pkg::DPW_IDLE: begin
					oe_d = 1'b0;
				end
				default: begin
					st_d = dpw_pkg::DPW_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q    <= dpw_pkg::DPW_IDLE;
			ph_q    <= dpw_pkg::DPW_PH_ADDR;
			cnt_q   <= dpw_pkg::DPW_BIT_FIRST;
			sh_q    <= 7'h00;
			tx_q    <= 8'h00;
			rw_q    <= 1'b0;
			mack_q  <= 1'b0;
			oe_q    <= 1'b0;
			wiper_q <= dpw_pkg::DPW_WIPER_RST;
			rs_q    <= 1'b0;
			sd_q    <= 1'b0;
			upd_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			ph_q    <= ph_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			rw_q    <= rw_d;
			mack_q  <= mack_d;
			oe_q    <= oe_d;
			wiper_q <= wiper_d;
			rs_q    <= rs_d;
			sd_q    <= sd_d;
			upd_q   <= upd_d;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	logic addr_q;
	logic addr_d;
	logic drv_q;

	// Selected flag follows the next state so it lines up with the enable
	always_comb begin
		addr_d = (st_d == dpw_pkg::DPW_ACK && ph_d != dpw_pkg::DPW_PH_ADDR)
			|| (st_d == dpw_pkg::DPW_ACK && oe_d)
			|| st_d == dpw_pkg::DPW_TX || st_d == dpw_pkg::DPW_MACK
			|| (st_d == dpw_pkg::DPW_RX && ph_d != dpw_pkg::DPW_PH_ADDR);
	end

	// Open drain: the driven level stays low, only the enable moves
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			drv_q  <= 1'b0;
			addr_q <= 1'b0;
		end else begin
			drv_q  <= 1'b0;
			addr_q <= addr_d;
		end
	end

	assign sda_drv                = drv_q;
	assign sda_drv_en             = oe_q;
	assign wiper_setting_register = wiper_q;
	assign shutdown_bit           = sd_q;
	assign midscale_reset_bit     = rs_q;
	assign wiper_update           = upd_q;
	assign addressed              = addr_q;
endmodule
`default_nettype wire

// [dpw_wiper_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module dpw_wiper_port_checker (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       address_select_pin,
	input  wire logic       sda_drv,
	input  wire logic       sda_drv_en,
	input  wire logic [7:0] wiper_setting_register,
	input  wire logic       shutdown_bit,
	input  wire logic       midscale_reset_bit,
	input  wire logic       wiper_update,
	input  wire logic       addressed
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_OPEN_DRAIN: assert property (sda_drv == 1'b0)
		else $error("data output not low");
	AST_STOP_IDLE: assert property (
		scl && $rose(sda) |-> ##[1:6] (!sda_drv_en && !addressed))
		else $error("stop did not release");
	AST_WIPER_CAUSE: assert property (
		!$stable(wiper_setting_register) |-> wiper_update || $past(wiper_update))
		else $error("wiper changed without update");
	AST_UPD_PULSE: assert property (wiper_update |=> !wiper_update)
		else $error("update longer than one cycle");
	AST_UPD_ADDR: assert property (wiper_update |-> addressed)
		else $error("update while not selected");
	AST_OE_ADDR: assert property (sda_drv_en |-> addressed)
		else $error("driving data while not selected");
	AST_OE_LOW_CLK: assert property ($rose(sda_drv_en) |-> !scl)
		else $error("data driven while clock high");
	AST_OE_HOLD: assert property ($rose(sda_drv_en) |=> sda_drv_en [*5])
		else $error("driven bit too short");
	AST_MIDSCALE: assert property (
		wiper_update && midscale_reset_bit
		|=> wiper_setting_register == dpw_pkg::DPW_MIDSCALE)
		else $error("midscale not stored");
	AST_SHUT_KEEP: assert property (
		$rose(shutdown_bit) && !midscale_reset_bit |-> $stable(wiper_setting_register))
		else $error("shutdown altered wiper");
endmodule
bind dpw_wiper_port dpw_wiper_port_checker dpw_wiper_port_checker_inst (
	.sys_clk(sys_clk), .rst_b(rst_b), .scl(scl), .sda(sda),
	.address_select_pin(address_select_pin), .sda_drv(sda_drv), .sda_drv_en(sda_drv_en),
	.wiper_setting_register(wiper_setting_register), .shutdown_bit(shutdown_bit),
	.midscale_reset_bit(midscale_reset_bit), .wiper_update(wiper_update), .addressed(addressed));
`default_nettype wire

// [dpw_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module dpw_bus_master (
	input  wire logic sys_clk,
	input  wire logic sda,
	output var logic  scl,
	output var logic  sda_lo
);
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	// Six system clocks a phase keeps well above the 3-cycle minimum
	task automatic hp();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task automatic start();
		hp();
		sda_lo = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	task automatic bitx(input logic b, output logic r);
		hp();
		sda_lo = !b;
		hp();
		scl = 1'b1;
		hp();
		r = sda;
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ak, a);
	endtask
	// Pull data low under a low clock, then release it with clock high
	task automatic stop();
		hp();
		sda_lo = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_lo = 1'b0;
		hp();
	endtask
endmodule
`default_nettype wire

// [test_dpw_wiper_port.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dpw_wiper_port;
	logic        sys_clk;
	logic        rst_b;
	logic        scl;
	logic        lo;
	logic [1:0]  so, oe, sd, ms, wu, ad;
	logic [15:0] wp;
	logic [7:0]  w [2];
	logic [7:0]  q, d;
	logic        a;
	int          error_cnt, check_count, seed, i;
	wire logic   sda = !(lo || |(oe & ~so));
	dpw_wiper_port dpw_wiper_port_inst [1:0] (.sys_clk(sys_clk), .rst_b(rst_b), .scl(scl),
		.sda(sda), .address_select_pin(2'b10), .sda_drv(so), .sda_drv_en(oe),
		.wiper_setting_register(wp), .shutdown_bit(sd), .midscale_reset_bit(ms),
		.wiper_update(wu), .addressed(ad));
	dpw_bus_master dpw_bus_master_inst (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_lo(lo));
	function automatic logic [7:0] exp_wiper(input logic [7:0] ins, input logic [7:0] dat);
		return ins[dpw_pkg::DPW_RS_BIT] ? dpw_pkg::DPW_MIDSCALE : dat;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkw();
		chk(wp[7:0], w[0]);
		chk(wp[15:8], w[1]);
	endtask
	// ************************************************
	// Transactions
	// ************************************************
	task automatic wr(input logic [7:0] ab, input logic [7:0] ins,
		input logic [7:0] dat, input int n);
		logic hit;
		hit = ab[7:2] == dpw_pkg::DPW_ADDR_FIXED;
		dpw_bus_master_inst.start();
		dpw_bus_master_inst.xfer(ab, 1'b1, q, a);
		chk({7'h0, a}, {7'h0, !hit});
		if (hit) begin
			dpw_bus_master_inst.xfer(ins, 1'b1, q, a);
			chk({7'h0, a}, 8'h00);
			for (int j = 0; j < n; j++) begin
				dpw_bus_master_inst.xfer(dat + 8'(j), 1'b1, q, a);
				w[ab[1]] = exp_wiper(ins, dat + 8'(j));
				chkw();
			end
		end
		dpw_bus_master_inst.stop();
		chk({6'h0, ad}, 8'h00);
		$display("write done t=%0t", $time);
	endtask
	task automatic rd(input logic s, input int n);
		dpw_bus_master_inst.start();
		dpw_bus_master_inst.xfer({dpw_pkg::DPW_ADDR_FIXED, s, 1'b1}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		for (int j = 0; j < n; j++) begin
			dpw_bus_master_inst.xfer(8'hff, 1'(j == n - 1), q, a);
			chk(q, w[s]);
		end
		dpw_bus_master_inst.stop();
		$display("read done t=%0t", $time);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		seed = 65264;
		error_cnt = 0;
		check_count = 0;
		rst_b = 1'b0;
		w[0] = 8'h80;
		w[1] = 8'h80;
		repeat (3) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		chkw();
		wr({dpw_pkg::DPW_ADDR_FIXED, 2'b00}, 8'h00, 8'($random(seed)), 3);
		rd(1'b0, 3);
		rd(1'b1, 1);
		wr({dpw_pkg::DPW_ADDR_FIXED, 2'b10}, 8'h40, 8'($random(seed)), 2);
		chk({7'h0, ms[1]}, 8'h01);
		wr({dpw_pkg::DPW_ADDR_FIXED, 2'b10}, 8'h20, 8'($random(seed)), 1);
		chk({7'h0, sd[1]}, 8'h01);
		chk({7'h0, ms[1]}, 8'h00);
		wr({dpw_pkg::DPW_ADDR_FIXED, 2'b10}, 8'h00, 8'($random(seed)), 1);
		chk({7'h0, sd[1]}, 8'h00);
		wr(8'h54, 8'h00, 8'h00, 0);
		for (i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			wr({dpw_pkg::DPW_ADDR_FIXED, d[0], 1'b0}, d & 8'h60, 8'($random(seed)), d[2:1] + 1);
			rd(d[0], d[5:4] + 1);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
